// [cmd_irq_pkg.sv]
package cmd_irq_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] OFF_RESERVED_ZERO   = 8'h00;
  localparam logic [7:0] OFF_COMMAND_LAUNCH  = 8'h04;
  localparam logic [7:0] OFF_MAIN_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_AUX_IRQ_ENABLE  = 8'h0C;
  localparam logic [7:0] OFF_MAIN_REQ_FLAGS  = 8'h10;
  localparam logic [7:0] OFF_AUX_REQ_FLAGS   = 8'h14;

  // ****************************************
  // Register indices as printed
  // ****************************************
  localparam logic [5:0] IDX_RESERVED_ZERO   = 6'h00;
  localparam logic [5:0] IDX_COMMAND_LAUNCH  = 6'h01;
  localparam logic [5:0] IDX_MAIN_IRQ_ENABLE = 6'h02;
  localparam logic [5:0] IDX_AUX_IRQ_ENABLE  = 6'h03;
  localparam logic [5:0] IDX_MAIN_REQ_FLAGS  = 6'h04;
  localparam logic [5:0] IDX_AUX_REQ_FLAGS   = 6'h05;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_RESERVED_ZERO   = 8'h00;
  localparam logic [7:0] RST_COMMAND_LAUNCH  = 8'h20;
  localparam logic [7:0] RST_MAIN_IRQ_ENABLE = 8'h80;
  localparam logic [7:0] RST_AUX_IRQ_ENABLE  = 8'h00;
  localparam logic [7:0] RST_MAIN_REQ_FLAGS  = 8'h14;

  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int         BIT_RECEIVER_OFF    = 5;
  localparam int         BIT_SLEEP_REQUEST   = 4;
  localparam int         BIT_POLARITY_INVERT = 7;
  localparam int         BIT_DRIVE_STYLE     = 7;
  localparam int         BIT_SET_OR_CLEAR    = 7;
  localparam int         BIT_CARD_ACTIVITY   = 4;
  localparam int         BIT_CHECKSUM_DONE   = 2;
  localparam logic [7:0] AUX_ENABLE_MASK     = 8'h94;
  localparam logic [7:0] AUX_FLAG_MASK       = 8'h14;
  localparam logic [6:0] MAIN_FLAG_MASK      = 7'h7F;

  // ****************************************
  // Operation codes
  // ****************************************
  localparam logic [3:0] OP_IDLE             = 4'h0;
  localparam logic [3:0] OP_SOFTWARE_RESTART = 4'hF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_PERIOD_NS       = 20;
  localparam int         WAKE_TIME_NS        = 1000;
  localparam int         WAKE_CYCLES         = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         RESTART_TIME_NS     = 400;
  localparam int         RESTART_CYCLES      = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WAKE_COUNT          = 8'(WAKE_CYCLES);
  localparam logic [7:0] RESTART_COUNT       = 8'(RESTART_CYCLES);

  // ****************************************
  // AHB encodings
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ       = 2'h2;
  localparam logic [1:0] HTRANS_SEQ          = 2'h3;
  localparam logic       HRESP_OKAY          = 1'h0;

  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_ASLEEP,
    PWR_WAKING
  } power_state_t;

endpackage

// [command_and_interrupt_regs.sv]
`timescale 1ns/10ps

// Notes on behaviour
// - Operation field launches command, reads current one
// - Bit 5 switches receiver analog off
// - Bit 4 set enters soft power-down
// - Clearing bit 4 wakes; reads one meanwhile
// - Power-down set ignored during software restart
// - Command register resets to 20h
// - Bit 7 inverts the interrupt pin
// - Main enable resets to 80h
// - Bits 6..0 gate seven main requests
// - Aux bit 7 selects push-pull or open-drain
// - Aux bit 4 gates card input activity
// - Aux bit 2 gates checksum done
// - Aux enable resets 00h, other bits reserved
// - Main request flags reset to 14h, aux flags to 00h
// - Address 00h reserved, reads zero
// - Flag write bit 7 sets or clears marked
module command_and_interrupt_regs (
  input  wire logic        hclk,                  // System clock, 50 MHz
  input  wire logic        hresetn,               // Async reset, active low
  input  wire logic        hsel,                  // Slave select
  input  wire logic [31:0] haddr,                 // Byte address
  input  wire logic [1:0]  htrans,                // Transfer type
  input  wire logic        hwrite,                // Write when high
  input  wire logic [2:0]  hsize,                 // Transfer size
  input  wire logic [31:0] hwdata,                // Write data
  input  wire logic        hready,                // Bus ready in
  output logic      [31:0] hrdata,                // Read data
  output logic             hreadyout,             // Slave ready
  output logic             hresp,                 // Always OKAY
  input  wire logic [6:0]  main_event,            // Pulses setting main flags
  input  wire logic        card_activity_event,   // Pulse from card-side input
  input  wire logic        checksum_done_event,   // Pulse from checksum unit
  input  wire logic        operation_done,        // Running command finished
  output logic             irq_out,               // Interrupt pin output value
  output logic             irq_oe_n,              // Pin enable, low drives
  output logic             combined_status,       // Unmasked request pending
  output logic [3:0]       active_operation,      // Command now executing
  output logic             command_start,         // One-cycle launch pulse
  output logic             receiver_analog_off,   // Analog receiver off
  output logic             powered_down           // Soft power-down state
);

  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic       wr_pend_q;
  logic [5:0] idx_q;

  // Capture valid transfers; every access is a single word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      idx_q     <= 6'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      idx_q     <= haddr[7:2];
    end
  end

  // Zero-wait answers, never an error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= cmd_irq_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= cmd_irq_pkg::HRESP_OKAY;
    end
  end

  function automatic logic hit(input logic [5:0] idx, input logic [5:0] want);
    hit = (idx == want);
  endfunction

  logic [7:0] wbyte;
  logic       wr_cmd;
  logic       wr_men;
  logic       wr_aen;
  logic       wr_mfl;
  logic       wr_afl;
  assign wbyte  = hwdata[7:0];
  assign wr_cmd = wr_pend_q && hit(idx_q, cmd_irq_pkg::IDX_COMMAND_LAUNCH);
  assign wr_men = wr_pend_q && hit(idx_q, cmd_irq_pkg::IDX_MAIN_IRQ_ENABLE);
  assign wr_aen = wr_pend_q && hit(idx_q, cmd_irq_pkg::IDX_AUX_IRQ_ENABLE);
  assign wr_mfl = wr_pend_q && hit(idx_q, cmd_irq_pkg::IDX_MAIN_REQ_FLAGS);
  assign wr_afl = wr_pend_q && hit(idx_q, cmd_irq_pkg::IDX_AUX_REQ_FLAGS);

  // ****************************************
  // Command register
  // ****************************************
  logic [3:0]                op_q;
  logic                      rcv_off_q;
  logic                      start_q;
  logic [7:0]                timer_q;
  cmd_irq_pkg::power_state_t pwr_q;
  logic                      sleep_bit;

  // Operation field and receiver control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q      <= cmd_irq_pkg::RST_COMMAND_LAUNCH[3:0];
      rcv_off_q <= cmd_irq_pkg::RST_COMMAND_LAUNCH[cmd_irq_pkg::BIT_RECEIVER_OFF];
      start_q   <= 1'b0;
    end else begin
      start_q <= wr_cmd;
      if (wr_cmd) begin
        op_q      <= wbyte[3:0];
        rcv_off_q <= wbyte[cmd_irq_pkg::BIT_RECEIVER_OFF];
      end else if (op_q == cmd_irq_pkg::OP_SOFTWARE_RESTART && timer_q == 8'h01) begin
        op_q <= cmd_irq_pkg::OP_IDLE;
      end else if (operation_done) begin
        op_q <= cmd_irq_pkg::OP_IDLE;
      end
    end
  end

  // Power-down and wake-up sequence; timer shared with restart timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_q   <= cmd_irq_pkg::PWR_AWAKE;
      timer_q <= 8'h00;
    end else begin
      if (wr_cmd && wbyte[3:0] == cmd_irq_pkg::OP_SOFTWARE_RESTART) begin
        timer_q <= cmd_irq_pkg::RESTART_COUNT;
      end else if (timer_q != 8'h00) begin
        timer_q <= timer_q - 8'h01;
      end
      case (pwr_q)
        cmd_irq_pkg::PWR_AWAKE: begin
          // Restart running, or being launched, blocks sleep
          if (wr_cmd && wbyte[cmd_irq_pkg::BIT_SLEEP_REQUEST] &&
              op_q != cmd_irq_pkg::OP_SOFTWARE_RESTART &&
              wbyte[3:0] != cmd_irq_pkg::OP_SOFTWARE_RESTART) begin
            pwr_q <= cmd_irq_pkg::PWR_ASLEEP;
          end
        end
        cmd_irq_pkg::PWR_ASLEEP: begin
          if (wr_cmd && !wbyte[cmd_irq_pkg::BIT_SLEEP_REQUEST]) begin
            pwr_q   <= cmd_irq_pkg::PWR_WAKING;
            timer_q <= cmd_irq_pkg::WAKE_COUNT;
          end
        end
        cmd_irq_pkg::PWR_WAKING: begin
          if (timer_q == 8'h01 || timer_q == 8'h00) begin
            pwr_q <= cmd_irq_pkg::PWR_AWAKE;
          end
        end
        default: pwr_q <= cmd_irq_pkg::PWR_AWAKE;
      endcase
    end
  end

  assign sleep_bit = (pwr_q != cmd_irq_pkg::PWR_AWAKE);

  // ****************************************
  // Enable registers
  // ****************************************
  logic [7:0] men_q;
  logic [7:0] aen_q;

  // Enables; reserved aux bits never store
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      men_q <= cmd_irq_pkg::RST_MAIN_IRQ_ENABLE;
      aen_q <= cmd_irq_pkg::RST_AUX_IRQ_ENABLE;
    end else begin
      if (wr_men) begin
        men_q <= wbyte;
      end
      if (wr_aen) begin
        aen_q <= wbyte & cmd_irq_pkg::AUX_ENABLE_MASK;
      end
    end
  end

  // ****************************************
  // Request flags
  // ****************************************
  logic [6:0] mfl_q;
  logic [7:0] afl_q;
  logic [6:0] mfl_d;
  logic [7:0] afl_d;
  logic [7:0] aux_ev;

  assign aux_ev = {3'h0, card_activity_event, 1'b0, checksum_done_event, 2'h0};

  // Host write sets or clears marked bits; a same-cycle event wins
  always_comb begin
    mfl_d = mfl_q;
    afl_d = afl_q;
    if (wr_mfl) begin
      if (wbyte[cmd_irq_pkg::BIT_SET_OR_CLEAR]) begin
        mfl_d = mfl_q | wbyte[6:0];
      end else begin
        mfl_d = mfl_q & ~wbyte[6:0];
      end
    end
    if (wr_afl) begin
      if (wbyte[cmd_irq_pkg::BIT_SET_OR_CLEAR]) begin
        afl_d = afl_q | (wbyte & cmd_irq_pkg::AUX_FLAG_MASK);
      end else begin
        afl_d = afl_q & ~(wbyte & cmd_irq_pkg::AUX_FLAG_MASK);
      end
    end
    mfl_d = mfl_d | (main_event & cmd_irq_pkg::MAIN_FLAG_MASK);
    afl_d = afl_d | aux_ev;
  end

  // Flags are sticky until the host clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mfl_q <= cmd_irq_pkg::RST_MAIN_REQ_FLAGS[6:0];
      afl_q <= 8'h00;
    end else begin
      mfl_q <= mfl_d;
      afl_q <= afl_d;
    end
  end

  // ****************************************
  // Interrupt pin
  // ****************************************
  logic status_d;
  logic pin_level;

  assign status_d = |(mfl_d & men_q[6:0]) |
                    (afl_d[cmd_irq_pkg::BIT_CARD_ACTIVITY] & aen_q[cmd_irq_pkg::BIT_CARD_ACTIVITY]) |
                    (afl_d[cmd_irq_pkg::BIT_CHECKSUM_DONE] & aen_q[cmd_irq_pkg::BIT_CHECKSUM_DONE]);
  assign pin_level = men_q[cmd_irq_pkg::BIT_POLARITY_INVERT] ? !status_d : status_d;

  // Open drain pulls low only; released level reads high externally
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      combined_status <= 1'b0;
      irq_out         <= 1'b0;
      irq_oe_n        <= 1'b1;
    end else begin
      combined_status <= status_d;
      irq_out         <= pin_level;
      irq_oe_n        <= aen_q[cmd_irq_pkg::BIT_DRIVE_STYLE] ? 1'b0 : pin_level;
    end
  end

  // ****************************************
  // Read data and status outputs
  // ****************************************
  logic [7:0] rd_byte;

  // Reserved and unmapped offsets in the low 256 bytes read zero; only haddr[7:2] decoded from the address phase
  always_comb begin
    case (haddr[7:2])
      cmd_irq_pkg::IDX_RESERVED_ZERO:   rd_byte = cmd_irq_pkg::RST_RESERVED_ZERO;
      cmd_irq_pkg::IDX_COMMAND_LAUNCH:  rd_byte = {2'h0, rcv_off_q, sleep_bit, op_q};
      cmd_irq_pkg::IDX_MAIN_IRQ_ENABLE: rd_byte = men_q;
      cmd_irq_pkg::IDX_AUX_IRQ_ENABLE:  rd_byte = aen_q;
      cmd_irq_pkg::IDX_MAIN_REQ_FLAGS:  rd_byte = {1'b0, mfl_q};
      cmd_irq_pkg::IDX_AUX_REQ_FLAGS:   rd_byte = afl_q;
      default:                          rd_byte = 8'h00;
    endcase
  end

  // Read data loaded at the address edge so it stands for the whole data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  // Mirrors of command state to the rest of the device
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_operation    <= cmd_irq_pkg::RST_COMMAND_LAUNCH[3:0];
      command_start       <= 1'b0;
      receiver_analog_off <= 1'b1;
      powered_down        <= 1'b0;
    end else begin
      active_operation    <= op_q;
      command_start       <= start_q;
      receiver_analog_off <= rcv_off_q;
      powered_down        <= (pwr_q == cmd_irq_pkg::PWR_ASLEEP);
    end
  end

endmodule // command_and_interrupt_regs

// [cmd_irq_regs_asserts.sv]
`timescale 1ns/10ps
// ****************************************
// Port checker
// ****************************************
module cmd_irq_regs_checker (
  input wire logic        hclk,                // Clock
  input wire logic        hresetn,             // Reset, low
  input wire logic        hsel,                // Select
  input wire logic [1:0]  htrans,              // Transfer type
  input wire logic        hwrite,              // Direction
  input wire logic        hready,              // Bus ready
  input wire logic [31:0] hrdata,              // Read data
  input wire logic        hreadyout,           // Slave ready
  input wire logic        hresp,               // Response
  input wire logic [6:0]  main_event,          // Main events
  input wire logic        card_activity_event, // Card event
  input wire logic        checksum_done_event, // Checksum event
  input wire logic        irq_out,             // Pin value
  input wire logic        irq_oe_n,            // Pin enable
  input wire logic        combined_status,     // Pending request
  input wire logic [3:0]  active_operation,    // Running op
  input wire logic        command_start,       // Launch pulse
  input wire logic        receiver_analog_off, // Receiver off
  input wire logic        powered_down         // Asleep
);
  logic wr_q;    // Write data phase now
  logic cause_q; // Event or write seen

  // Remember recent causes, since status lags its cause by a cycle or two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      cause_q <= 1'b0;
    end else begin
      wr_q    <= hsel & hready & htrans[1] & hwrite;
      cause_q <= (|main_event) | card_activity_event | checksum_done_event | wr_q;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Register-driven outputs at reset, and bus response
  a_reset_state: assert property ($rose(hresetn) |-> irq_oe_n && receiver_analog_off && !powered_down
    && active_operation == 4'h0) else $error("outputs wrong after reset");
  a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus response or upper read data wrong");
  // Pin released only at the high level
  a_drain_release: assert property (irq_oe_n && $past(hresetn) |-> irq_out)
    else $error("pin released while low");
  a_start_pulse: assert property (command_start |=> !command_start)
    else $error("launch pulse longer than one cycle");
  // Sleep and wake sequencing
  a_sleep_blocked: assert property ($rose(powered_down) |-> active_operation != cmd_irq_pkg::OP_SOFTWARE_RESTART)
    else $error("sleep entered during restart");
  a_wake_hold: assert property ($fell(powered_down) |-> !powered_down [*8])
    else $error("sleep reentered during wake");
  // Pin and status relations
  a_pin_follows: assert property ($changed(combined_status) |-> $changed(irq_out))
    else $error("pin did not follow status");
  a_flag_sticky: assert property ($fell(combined_status) |-> wr_q || $past(wr_q) || $past(wr_q, 2)
    || $past(wr_q, 3)) else $error("status dropped without host write");
  a_status_cause: assert property ($rose(combined_status) |-> cause_q || $past(cause_q)
    || $past(cause_q, 2)) else $error("status rose without cause");

  // Main scenarios reached
  c_launch: cover property (command_start);
  c_sleep: cover property ($rose(powered_down));
  c_request: cover property ($rose(combined_status));
endmodule // cmd_irq_regs_checker

bind command_and_interrupt_regs cmd_irq_regs_checker chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .main_event, .card_activity_event, .checksum_done_event, .irq_out, .irq_oe_n,
  .combined_status, .active_operation, .command_start, .receiver_analog_off, .powered_down);

// [cmd_irq_host.sv]
`timescale 1ns/10ps
// ****************************************
// Host bus master model
// ****************************************
module cmd_irq_host (
  input  wire logic        hclk,   // Clock
  input  wire logic        hready, // Bus ready
  input  wire logic [31:0] hrdata, // Read data
  output logic             hsel,   // Select
  output logic [31:0]      haddr,  // Byte address
  output logic [1:0]       htrans, // Transfer type
  output logic             hwrite, // Direction
  output logic [2:0]       hsize,  // Always word
  output logic [31:0]      hwdata  // Write data
);
  // Idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer; each phase held until hready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= cmd_irq_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata[7:0];
    hwdata <= ~{24'h0, d}; // Released data must not look held
  endtask
endmodule // cmd_irq_host

// [command_and_interrupt_regs_test.sv]
`timescale 1ns/10ps
module command_and_interrupt_regs_test;
  // Bus, event and pin signals
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, card_activity_event, checksum_done_event;
  logic        operation_done, irq_out, irq_oe_n, combined_status, command_start, receiver_analog_off;
  logic        powered_down, start_seen;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [6:0]  main_event;
  logic [3:0]  active_operation;
  int          failures, num_checks;
  localparam logic [7:0] RST_READ [7] = '{8'h00, 8'h20, 8'h80, 8'h00, 8'h14, 8'h00, 8'h00};

  // ****************************************
  // Design and host model
  // ****************************************
  command_and_interrupt_regs dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .main_event, .card_activity_event, .checksum_done_event,
    .operation_done, .irq_out, .irq_oe_n, .combined_status, .active_operation, .command_start,
    .receiver_analog_off, .powered_down);
  cmd_irq_host host_u (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Launch pulse lasts one cycle, so latch it
  always @(posedge hclk) begin
    if (command_start === 1'b1) start_seen <= 1'b1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    host_u.xfer(1'b0, a, 8'h00, q);
  endtask
  // Flags and pin land one edge after the data phase
  task automatic settle();
    repeat (3) @(negedge hclk);
  endtask
  task automatic pulse(input logic [6:0] m, input logic c, input logic k, input logic d);
    @(posedge hclk);
    main_event          <= m;
    card_activity_event <= c;
    checksum_done_event <= k;
    operation_done      <= d;
    @(posedge hclk);
    main_event          <= 7'h00;
    card_activity_event <= 1'b0;
    checksum_done_event <= 1'b0;
    operation_done      <= 1'b0;
    settle();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [7:0] q;
    hresetn             = 1'b0;
    main_event          = 7'h00;
    card_activity_event = 1'b0;
    checksum_done_event = 1'b0;
    operation_done      = 1'b0;
    start_seen          = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), q);
      check("reset read", q, RST_READ[i]);
    end
    check("idle pin level", 8'(irq_out), 8'h01);
    check("idle pin enable", 8'(irq_oe_n), 8'h01);
    $display("reset test done");
    // Set and clear selector, reserved bits, drive style
    wr(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, 8'h7F);
    rd(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, q);
    check("flags cleared", q, 8'h00);
    wr(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, 8'hD5);
    rd(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, q);
    check("flags set", q, 8'h55);
    wr(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, 8'h05);
    rd(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, q);
    check("flags part cleared", q, 8'h50);
    wr(cmd_irq_pkg::OFF_RESERVED_ZERO, 8'hFF);
    rd(cmd_irq_pkg::OFF_RESERVED_ZERO, q);
    check("reserved read", q, 8'h00);
    wr(cmd_irq_pkg::OFF_AUX_IRQ_ENABLE, 8'hFF);
    rd(cmd_irq_pkg::OFF_AUX_IRQ_ENABLE, q);
    check("aux enable read", q, 8'h94);
    settle();
    check("push-pull enable", 8'(irq_oe_n), 8'h00);
    wr(cmd_irq_pkg::OFF_AUX_IRQ_ENABLE, 8'h00);
    settle();
    check("open drain released", 8'(irq_oe_n), 8'h01);
    wr(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, 8'h7F);
    $display("register test done");
    // Each main request: masked, unmasked, inverted, then cleared by the host
    for (int i = 0; i < 7; i++) begin
      wr(cmd_irq_pkg::OFF_MAIN_IRQ_ENABLE, 8'h00);
      pulse(7'(1 << i), 1'b0, 1'b0, 1'b0);
      check("masked status", 8'(combined_status), 8'h00);
      wr(cmd_irq_pkg::OFF_MAIN_IRQ_ENABLE, 8'(1 << i));
      settle();
      check("unmasked status", 8'(combined_status), 8'h01);
      check("direct pin", 8'(irq_out), 8'h01);
      wr(cmd_irq_pkg::OFF_MAIN_IRQ_ENABLE, 8'(8'h80 | (1 << i)));
      settle();
      check("inverted pin", 8'(irq_out), 8'h00);
      check("flag held", 8'(combined_status), 8'h01);
      wr(cmd_irq_pkg::OFF_MAIN_REQ_FLAGS, 8'(1 << i));
      settle();
      check("cleared status", 8'(combined_status), 8'h00);
    end
    wr(cmd_irq_pkg::OFF_MAIN_IRQ_ENABLE, 8'h00);
    for (int j = 0; j < 2; j++) begin
      wr(cmd_irq_pkg::OFF_AUX_IRQ_ENABLE, j == 0 ? 8'h10 : 8'h04);
      pulse(7'h00, j == 0, j == 1, 1'b0);
      check("aux status", 8'(combined_status), 8'h01);
      rd(cmd_irq_pkg::OFF_AUX_REQ_FLAGS, q);
      check("aux flag", q, j == 0 ? 8'h10 : 8'h04);
      wr(cmd_irq_pkg::OFF_AUX_REQ_FLAGS, j == 0 ? 8'h10 : 8'h04);
      settle();
      check("aux cleared", 8'(combined_status), 8'h00);
    end
    wr(cmd_irq_pkg::OFF_AUX_IRQ_ENABLE, 8'h00);
    $display("interrupt test done");
    // Launch, receiver control, completion
    wr(cmd_irq_pkg::OFF_COMMAND_LAUNCH, 8'h03);
    settle();
    check("launch pulse", 8'(start_seen), 8'h01);
    check("running op", 8'(active_operation), 8'h03);
    check("receiver on", 8'(receiver_analog_off), 8'h00);
    rd(cmd_irq_pkg::OFF_COMMAND_LAUNCH, q);
    check("command read", q, 8'h03);
    pulse(7'h00, 1'b0, 1'b0, 1'b1);
    rd(cmd_irq_pkg::OFF_COMMAND_LAUNCH, q);
    check("op finished", q, 8'h00);
    wr(cmd_irq_pkg::OFF_COMMAND_LAUNCH, 8'h20);
    settle();
    check("receiver off", 8'(receiver_analog_off), 8'h01);
    // Sleep, then a wake that reads one until done
    wr(cmd_irq_pkg::OFF_COMMAND_LAUNCH, 8'h30);
    settle();
    check("asleep", 8'(powered_down), 8'h01);
    wr(cmd_irq_pkg::OFF_COMMAND_LAUNCH, 8'h20);
    rd(cmd_irq_pkg::OFF_COMMAND_LAUNCH, q);
    check("waking bit", q & 8'h10, 8'h10);
    check("not asleep", 8'(powered_down), 8'h00);
    repeat (60) @(negedge hclk);
    rd(cmd_irq_pkg::OFF_COMMAND_LAUNCH, q);
    check("awake read", q, 8'h20);
    // Sleep request during a restart must be dropped
    wr(cmd_irq_pkg::OFF_COMMAND_LAUNCH, 8'h2F);
    wr(cmd_irq_pkg::OFF_COMMAND_LAUNCH, 8'h3F);
    settle();
    check("sleep blocked", 8'(powered_down), 8'h00);
    rd(cmd_irq_pkg::OFF_COMMAND_LAUNCH, q);
    check("sleep bit clear", q & 8'h10, 8'h00);
    repeat (60) @(negedge hclk);
    rd(cmd_irq_pkg::OFF_COMMAND_LAUNCH, q);
    check("restart ended", q & 8'h0F, 8'h00);
    $display("command test done");
    report_and_stop();
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    report_and_stop();
  end
endmodule // command_and_interrupt_regs_test
